// File: core/sew_pkg.sv
package sew_pkg;

	// ****************************************************************
	// Frame and array geometry
	// ****************************************************************
	localparam int unsigned FRAME_BITS = 8;
	localparam int unsigned OP_W       = 3;
	localparam int unsigned ADDR_W     = FRAME_BITS - 1 - OP_W;
	localparam int unsigned WORD_W     = 16;
	localparam int unsigned MEM_DEPTH  = 1 << ADDR_W;
	localparam int unsigned CNT_W      = 5;

	// ****************************************************************
	// Instruction codes, adjustable to the target instruction table
	// ****************************************************************
	localparam logic [OP_W-1:0] OP_READ      = 3'h6;
	localparam logic [OP_W-1:0] OP_PROGRAM   = 3'h5;
	localparam logic [OP_W-1:0] OP_WRITE_ALL = 3'h1;
	localparam logic [OP_W-1:0] OP_ERASE_ALL = 3'h2;
	localparam logic [OP_W-1:0] OP_WRITE_EN  = 3'h3;
	localparam logic [OP_W-1:0] OP_WRITE_DIS = 3'h0;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_HZ              = 10_000_000;
	localparam int unsigned SELF_TIMED_TYP_US   = 4_000;
	localparam int unsigned SELF_TIMED_MAX_US   = 10_000;
	localparam int unsigned DESELECT_INTERVAL_NS = 200;
	localparam int unsigned SELF_TIMED_CYCLES   = SELF_TIMED_TYP_US * (CLK_HZ / 1_000_000);
	localparam int unsigned SELF_TIMED_MAX_CYC  = SELF_TIMED_MAX_US * (CLK_HZ / 1_000_000);
	localparam int unsigned TIMER_W             = 32;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT,
		ST_CMD,
		ST_READ,
		ST_WDATA,
		ST_ARMED,
		ST_BUSY
	} sew_state_t;

	typedef struct packed {
		logic cs;
		logic sk;
		logic di;
	} sew_pins_t;

	typedef struct packed {
		sew_state_t         st;
		logic [CNT_W-1:0]   cnt;
		logic [OP_W-1:0]    op;
		logic [ADDR_W-1:0]  addr;
		logic [WORD_W-1:0]  sh;
		logic [CNT_W-1:0]   dcnt;
		logic               wel;
		logic               poll;
		logic               dout;
		logic               doe;
		logic [TIMER_W-1:0] timer;
		logic [ADDR_W:0]    sweep;
		logic               fill;
		logic [WORD_W-1:0]  wdat;
	} sew_regs_t;

	localparam sew_regs_t REGS_RST = '0;

endpackage

// File: core/sew_sync3.sv
`timescale 1ns/1ps
module sew_sync3 #(
	parameter int unsigned W = 3
) (
	input  wire logic         clk_i,   // Sampling clock
	input  wire logic         rst_n_i, // Synchronised reset, active low
	input  wire logic         ce_i,    // Clock enable
	input  wire logic [W-1:0] d_i,     // Asynchronous inputs
	output logic      [W-1:0] lvl_o,   // Accepted level
	output logic      [W-1:0] rise_o,  // One-cycle pulse on accepted rise
	output logic      [W-1:0] fall_o   // One-cycle pulse on accepted fall
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] lvl_q;
	logic [W-1:0] agree;

	// ****************************************************************
	// Three stages; a change counts once stages two and three agree
	// ****************************************************************
	assign agree  = ~(s2_q ^ s3_q);
	assign rise_o = agree & s3_q & ~lvl_q;
	assign fall_o = agree & ~s3_q & lvl_q;
	assign lvl_o  = lvl_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			lvl_q <= '0;
		end
		else if (ce_i)
		begin
			s1_q  <= d_i;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= (lvl_q & ~agree) | (s3_q & agree);
		end
	end

endmodule

// File: core/sew_eeprom.sv
`timescale 1ns/1ps
module sew_eeprom #(
	parameter int unsigned WRITE_CYCLES = sew_pkg::SELF_TIMED_CYCLES
) (
	input  wire logic ref_clk_i,         // 10 MHz system clock
	input  wire logic reset_n_i,         // Asynchronous reset, active low
	input  wire logic ce_i,              // Clock enable, freezes state when low
	input  wire logic chip_select_i,     // Chip select pin, active high
	input  wire logic serial_clock_in_i, // Serial clock pin
	input  wire logic serial_data_in_i,  // Serial data-in pin
	output logic      data_out_o,        // Serial data-out level
	output logic      data_out_oe_o      // High while data-out is driven
);

	logic [1:0]                         rst_sync_q;
	logic                               rst_n;
	sew_pkg::sew_pins_t                 pins;
	sew_pkg::sew_pins_t                 lvl;
	sew_pkg::sew_pins_t                 rise;
	sew_pkg::sew_pins_t                 fall;
	sew_pkg::sew_regs_t                 r_q;
	sew_pkg::sew_regs_t                 r_d;
	logic [sew_pkg::WORD_W-1:0]         mem_q [sew_pkg::MEM_DEPTH];
	logic                               we;
	logic [sew_pkg::ADDR_W-1:0]         waddr;
	logic [sew_pkg::WORD_W-1:0]         wdata;
	logic                               start_seen;
	logic [sew_pkg::FRAME_BITS-2:0]     frame;
	logic [sew_pkg::ADDR_W-1:0]         next_addr;

	function automatic logic is_write_op(input logic [sew_pkg::OP_W-1:0] op);
		is_write_op = (op == sew_pkg::OP_PROGRAM) || (op == sew_pkg::OP_WRITE_ALL);
	endfunction

	// Single and bulk writes share one countdown load
	function automatic logic [sew_pkg::TIMER_W-1:0] write_time_load();
		write_time_load = sew_pkg::TIMER_W'(WRITE_CYCLES - 1);
	endfunction

	// ****************************************************************
	// Reset release and pin sampling
	// ****************************************************************
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	assign rst_n = rst_sync_q[1];
	assign pins  = '{cs: chip_select_i, sk: serial_clock_in_i, di: serial_data_in_i};

	sew_sync3 #(
		.W(3)
	) u_sync (
		.clk_i   (ref_clk_i),
		.rst_n_i (rst_n),
		.ce_i    (ce_i),
		.d_i     (pins),
		.lvl_o   (lvl),
		.rise_o  (rise),
		.fall_o  (fall)
	);

	assign frame     = {r_q.sh[sew_pkg::FRAME_BITS-3:0], lvl.di};
	assign next_addr = r_q.addr + sew_pkg::ADDR_W'(1);

	// ****************************************************************
	// Command sequencer
	// ****************************************************************
	always_comb
	begin
		r_d        = r_q;
		we         = 1'b0;
		waddr      = r_q.addr;
		wdata      = r_q.wdat;
		start_seen = 1'b0;
		if (r_q.st == sew_pkg::ST_BUSY)
		begin
			// Array sweep for the bulk commands, one word per cycle
			if (r_q.fill && !r_q.sweep[sew_pkg::ADDR_W])
			begin
				we      = 1'b1;
				waddr   = r_q.sweep[sew_pkg::ADDR_W-1:0];
				r_d.sweep = r_q.sweep + (sew_pkg::ADDR_W+1)'(1);
			end
			if (r_q.timer == '0)
			begin
				r_d.poll = 1'b1;
				r_d.st   = lvl.cs ? sew_pkg::ST_WAIT : sew_pkg::ST_IDLE;
			end
			else
				r_d.timer = r_q.timer - sew_pkg::TIMER_W'(1);
		end
		else if (fall.cs)
		begin
			r_d.st = sew_pkg::ST_IDLE;
			if (r_q.wel && r_q.st == sew_pkg::ST_WDATA && is_write_op(r_q.op)
				&& r_q.dcnt == sew_pkg::CNT_W'(sew_pkg::WORD_W))
			begin
				r_d.st    = sew_pkg::ST_BUSY;
				r_d.timer = write_time_load();
				r_d.sweep = '0;
				r_d.fill  = (r_q.op == sew_pkg::OP_WRITE_ALL);
				we        = (r_q.op == sew_pkg::OP_PROGRAM);
			end
			else if (r_q.wel && r_q.st == sew_pkg::ST_ARMED
				&& r_q.op == sew_pkg::OP_ERASE_ALL)
			begin
				r_d.st    = sew_pkg::ST_BUSY;
				r_d.timer = write_time_load();
				r_d.sweep = '0;
				r_d.fill  = 1'b1;
				r_d.wdat  = '1;
			end
		end
		else if (!lvl.cs)
			r_d.st = sew_pkg::ST_IDLE;
		else
		begin
			// Selected and idle of writes: walk the frame, read or data phase
			case (r_q.st)
				sew_pkg::ST_IDLE:
					r_d.st = sew_pkg::ST_WAIT;
				sew_pkg::ST_WAIT:
					if (rise.sk && lvl.di)
					begin
						start_seen = 1'b1;
						r_d.poll   = 1'b0;
						r_d.cnt    = '0;
						r_d.st     = sew_pkg::ST_CMD;
					end
				sew_pkg::ST_CMD:
					if (rise.sk)
					begin
						r_d.sh  = {r_q.sh[sew_pkg::WORD_W-2:0], lvl.di};
						r_d.cnt = r_q.cnt + sew_pkg::CNT_W'(1);
						if (r_q.cnt == sew_pkg::CNT_W'(sew_pkg::FRAME_BITS - 2))
						begin
							r_d.op   = frame[sew_pkg::FRAME_BITS-2 -: sew_pkg::OP_W];
							r_d.addr = frame[sew_pkg::ADDR_W-1:0];
							r_d.cnt  = '0;
							r_d.dcnt = '0;
							r_d.st   = sew_pkg::ST_ARMED;
							if (r_d.op == sew_pkg::OP_READ)
							begin
								r_d.sh = mem_q[r_d.addr];
								r_d.st = sew_pkg::ST_READ;
							end
							else if (is_write_op(r_d.op))
								r_d.st = sew_pkg::ST_WDATA;
							else if (r_d.op == sew_pkg::OP_WRITE_EN)
								r_d.wel = 1'b1;
							else if (r_d.op == sew_pkg::OP_WRITE_DIS)
								r_d.wel = 1'b0;
						end
					end
				sew_pkg::ST_READ:
					// One bit per falling serial clock, next word preloaded
					if (fall.sk)
					begin
						r_d.dout = r_q.sh[sew_pkg::WORD_W-1];
						r_d.sh   = {r_q.sh[sew_pkg::WORD_W-2:0], 1'b0};
						r_d.cnt  = r_q.cnt + sew_pkg::CNT_W'(1);
						if (r_q.cnt == sew_pkg::CNT_W'(sew_pkg::WORD_W - 1))
						begin
							r_d.cnt  = '0;
							r_d.addr = next_addr;
							r_d.sh   = mem_q[next_addr];
						end
					end
				sew_pkg::ST_WDATA:
					// Overflowing data simply pushes older bits out
					if (rise.sk)
					begin
						r_d.wdat = {r_q.wdat[sew_pkg::WORD_W-2:0], lvl.di};
						if (r_q.dcnt != sew_pkg::CNT_W'(sew_pkg::WORD_W))
							r_d.dcnt = r_q.dcnt + sew_pkg::CNT_W'(1);
					end
				default:
					r_d.st = r_q.st;
			endcase
		end
		// Data-out drive follows the state reached
		if (r_d.st == sew_pkg::ST_BUSY)
		begin
			r_d.doe  = lvl.cs;
			r_d.dout = 1'b0;
		end
		else if (r_d.st == sew_pkg::ST_READ)
			r_d.doe = 1'b1;
		else if (r_d.poll)
		begin
			r_d.doe  = lvl.cs;
			r_d.dout = 1'b1;
		end
		else
		begin
			r_d.doe  = 1'b0;
			r_d.dout = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			r_q <= sew_pkg::REGS_RST;
		else if (ce_i)
			r_q <= r_d;
	end

	// ****************************************************************
	// Word array, not reset
	// ****************************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (ce_i && we)
			mem_q[waddr] <= wdata;
	end

	assign data_out_o    = r_q.dout;
	assign data_out_oe_o = r_q.doe;

	// ****************************************************************
	// Checks
	// ****************************************************************
	logic [sew_pkg::TIMER_W-1:0] busy_len_q;
	logic                        busy;

	assign busy = (r_q.st == sew_pkg::ST_BUSY);

	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			busy_len_q <= '0;
		else if (ce_i)
			busy_len_q <= busy ? busy_len_q + sew_pkg::TIMER_W'(1) : '0;
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n || !ce_i);

	a_no_false_start: assert property (
		r_q.st == sew_pkg::ST_WAIT && lvl.cs && !lvl.di && !busy |=> r_q.st != sew_pkg::ST_CMD)
		else $error("start recognised with data-in low");
	a_standby_release: assert property (
		!lvl.cs && r_q.st != sew_pkg::ST_READ |=> !data_out_oe_o)
		else $error("data-out driven while deselected");
	a_write_needs_latch: assert property (
		$rose(busy) |-> $past(r_q.wel))
		else $error("write started with latch clear");
	a_busy_drives_low: assert property (
		busy && lvl.cs ##1 busy && lvl.cs |-> data_out_oe_o && !data_out_o)
		else $error("data-out not low while writing");
	a_write_duration: assert property (
		$fell(busy) |-> $past(busy_len_q) == sew_pkg::TIMER_W'(WRITE_CYCLES - 1))
		else $error("self-timed write length wrong");
	a_ready_level: assert property (
		r_q.poll && !busy && lvl.cs ##1 r_q.poll && lvl.cs |-> data_out_oe_o && data_out_o)
		else $error("ready level not shown");
	a_start_releases: assert property (
		start_seen |=> !data_out_oe_o && !r_q.poll)
		else $error("data-out not released on start");
	a_read_wraps: assert property (
		r_q.st == sew_pkg::ST_READ && fall.sk && lvl.cs
		&& r_q.cnt == sew_pkg::CNT_W'(sew_pkg::WORD_W - 1)
		|=> r_q.addr == $past(next_addr))
		else $error("read address did not advance");
	a_busy_ignores: assert property (
		busy && r_q.timer != '0 |=> busy)
		else $error("write aborted by input activity");

	// ****************************************************************
	// Read path, standby, refusal and write-bound checks
	// ****************************************************************
	a_read_bit_out: assert property (
		r_q.st == sew_pkg::ST_READ && fall.sk && !fall.cs && lvl.cs
		|=> data_out_o == $past(r_q.sh[sew_pkg::WORD_W-1]))
		else $error("read bit not shifted out");
	a_standby_holds: assert property (
		!lvl.cs && r_q.st == sew_pkg::ST_IDLE
		|=> r_q.st == sew_pkg::ST_IDLE)
		else $error("port left standby without select");
	a_locked_refuse: assert property (
		fall.cs && !r_q.wel && r_q.st != sew_pkg::ST_BUSY
		|=> !busy)
		else $error("write started while disabled");
	a_write_bound: assert property (
		busy |-> busy_len_q < sew_pkg::TIMER_W'(sew_pkg::SELF_TIMED_MAX_CYC))
		else $error("self-timed write too long");

	// ****************************************************************
	// Coverage of the main scenarios
	// ****************************************************************
	c_read_next_word: cover property (
		r_q.st == sew_pkg::ST_READ && r_q.addr == '1
		##1 r_q.st == sew_pkg::ST_READ && r_q.addr == '0);
	c_refused_write: cover property (
		fall.cs && !r_q.wel && r_q.st == sew_pkg::ST_ARMED);
	c_program_run: cover property ($rose(busy) && !r_q.fill);
	c_bulk_run: cover property ($rose(busy) && r_q.fill);
	c_poll_ready: cover property ($fell(busy) ##[1:20] data_out_oe_o && data_out_o);

endmodule

// File: verif/sew_host_model.sv
`timescale 1ns/1ps
module sew_host_model (
	input  wire logic ref_clk_i,      // System clock
	input  wire logic data_out_i,     // Device data-out level
	input  wire logic data_out_oe_i,  // Device data-out enable
	output logic      chip_select_o,  // Chip select
	output logic      serial_clock_o, // Serial clock, 800 ns period
	output logic      serial_data_o   // Serial data-in, separate wire from data-out
);
	// ****************************************************************
	// Host side of the serial port
	// ****************************************************************
	logic ready_oe;
	logic start_oe;

	initial
	begin
		chip_select_o  = 1'b0;
		serial_clock_o = 1'b0;
		serial_data_o  = 1'b0;
		ready_oe       = 1'b0;
		start_oe       = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// Data changes while the clock is low; data-out sampled in the high phase
	task automatic sk_bit(input logic b, output logic q);
		serial_clock_o <= 1'b0;
		serial_data_o  <= b;
		tick(4);
		serial_clock_o <= 1'b1;
		tick(2);
		q = data_out_i;
		tick(2);
	endtask

	// Leaves the serial clock high so a read can go on clocking
	task automatic frame(input logic [2:0] op, input logic [3:0] a, input int nd,
		input logic [31:0] d);
		logic [39:0] v;
		logic        q;
		v = {1'b1, op, a, d << (32 - nd)};
		chip_select_o <= 1'b1;
		tick(4);
		sk_bit(1'b0, q);
		sk_bit(1'b0, q);
		ready_oe = data_out_oe_i & data_out_i;
		for (int i = 0; i < 8 + nd; i++)
		begin
			sk_bit(v[39 - i], q);
			if (i == 1)
				start_oe = data_out_oe_i;
		end
	endtask

	task automatic deselect();
		serial_clock_o <= 1'b0;
		serial_data_o  <= 1'b0;
		tick(4);
		chip_select_o <= 1'b0;
		tick(6);
	endtask

	task automatic read_words(input logic [3:0] a, input int n, output logic [63:0] ws);
		logic q;
		ws = '0;
		frame(sew_pkg::OP_READ, a, 0, 32'h0000_0000);
		for (int i = 0; i < 16 * n; i++)
		begin
			sk_bit(1'b0, q);
			ws = {ws[62:0], q};
		end
		deselect();
	endtask

	task automatic select_look(output logic oe);
		chip_select_o <= 1'b1;
		tick(6);
		oe = data_out_oe_i;
	endtask

	// Either holds select high or toggles it per sample; ends with select high
	task automatic poll(input bit hold, output logic busy0, output int n);
		serial_data_o <= 1'b0;
		chip_select_o <= 1'b1;
		tick(6);
		busy0 = data_out_oe_i & ~data_out_i;
		n = 0;
		while (!(data_out_oe_i === 1'b1 && data_out_i === 1'b1) && n < 1000)
		begin
			if (!hold)
			begin
				chip_select_o <= 1'b0;
				tick(6);
				chip_select_o <= 1'b1;
			end
			tick(6);
			n++;
		end
	endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int unsigned WCYC = 400;

	logic ref_clk_i;
	logic reset_n_i;
	logic cs;
	logic sk;
	logic di;
	logic dout;
	logic doe;
	int   error_cnt   = 0;
	int   check_count = 0;

	sew_eeprom #(.WRITE_CYCLES(WCYC)) dut (
		.ref_clk_i         (ref_clk_i),
		.reset_n_i         (reset_n_i),
		.ce_i              (1'b1),
		.chip_select_i     (cs),
		.serial_clock_in_i (sk),
		.serial_data_in_i  (di),
		.data_out_o        (dout),
		.data_out_oe_o     (doe)
	);

	sew_host_model host (
		.ref_clk_i      (ref_clk_i),
		.data_out_i     (dout),
		.data_out_oe_i  (doe),
		.chip_select_o  (cs),
		.serial_clock_o (sk),
		.serial_data_o  (di)
	);

	initial
	begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	// ****************************************************************
	// Checking and shared sequences
	// ****************************************************************
	task automatic chk(input bit ok, input string m);
		check_count++;
		if (!ok)
		begin
			error_cnt++;
			$display("MISMATCH at %0t: %s", $time, m);
		end
	endtask

	task automatic wr(input logic [2:0] op, input logic [3:0] a, input int nd,
		input logic [31:0] d);
		host.frame(op, a, nd, d);
		host.deselect();
	endtask

	task automatic wait_ready(input bit hold);
		logic b;
		int   n;
		host.poll(hold, b, n);
		chk(b === 1'b1, "no busy level after write start");
		chk(n * (hold ? 6 : 12) <= WCYC + 36, "write not finished in time");
		host.deselect();
	endtask

	task automatic rd(input logic [3:0] a, input int n, input logic [47:0] exp);
		logic [63:0] w;
		host.read_words(a, n, w);
		chk(w[47:0] === exp, "read data wrong");
	endtask

	task automatic t_locked();
		logic oe;
		wr(sew_pkg::OP_ERASE_ALL, 4'h0, 0, 32'h0000_0000);
		host.select_look(oe);
		chk(oe === 1'b0, "write ran while disabled");
		host.deselect();
	endtask

	task automatic t_erase();
		wr(sew_pkg::OP_WRITE_EN, 4'h0, 0, 32'h0000_0000);
		wr(sew_pkg::OP_ERASE_ALL, 4'h7, 0, 32'h0000_0000);
		wait_ready(1'b1);
	endtask

	task automatic t_program();
		wr(sew_pkg::OP_PROGRAM, 4'h0, 16, 32'h0000_00ff);
		wait_ready(1'b0);
		wr(sew_pkg::OP_PROGRAM, 4'h0, 16, 32'h0000_a5a5);
		wait_ready(1'b0);
		wr(sew_pkg::OP_PROGRAM, 4'hf, 20, 32'h000f_1234);
		wait_ready(1'b0);
	endtask

	task automatic t_release();
		logic [63:0] w;
		host.read_words(4'hf, 3, w);
		chk(host.ready_oe === 1'b1, "ready level not shown on select");
		chk(host.start_oe === 1'b0, "data-out not released by start");
		chk(w[47:0] === 48'h1234_a5a5_ffff, "sequential read wrong");
	endtask

	// A write-disable sent while busy must be ignored, so the next program still runs
	task automatic t_busy();
		wr(sew_pkg::OP_WRITE_ALL, 4'h9, 20, 32'h000a_0f0f);
		wr(sew_pkg::OP_WRITE_DIS, 4'h0, 0, 32'h0000_0000);
		wait_ready(1'b1);
		wr(sew_pkg::OP_PROGRAM, 4'h5, 16, 32'h0000_0000);
		wait_ready(1'b0);
		rd(4'h4, 3, 48'h0f0f_0000_0f0f);
	endtask

	task automatic t_disable();
		logic oe;
		wr(sew_pkg::OP_WRITE_DIS, 4'h0, 0, 32'h0000_0000);
		wr(sew_pkg::OP_PROGRAM, 4'h5, 16, 32'h0000_1111);
		host.select_look(oe);
		chk(oe === 1'b0, "program ran after disable");
		host.deselect();
		rd(4'h5, 1, 48'h0000_0000_0000);
	endtask

	task automatic wrap_up();
		$display("Errors: %0d, checks: %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		error_cnt++;
		$display("MISMATCH at %0t: run did not finish", $time);
		wrap_up();
	end

	initial
	begin
		reset_n_i = 1'b0;
		repeat (3) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		t_locked();
		t_erase();
		t_program();
		t_release();
		t_busy();
		t_disable();
		wrap_up();
	end
endmodule
